// >>> spm_defines.svh
// constants for the speed command and profile mapper
// assumes a 25 MHz core clock and a 12-bit duty scale
`ifndef SPM_DEFINES_SVH
`define SPM_DEFINES_SVH

`define SPM_CLK_HZ         25000000
`define SPM_DUTY_W         12
`define SPM_DUTY_FS        12'hFFF
`define SPM_VMAG_W         15
`define SPM_VEL_W          16
`define SPM_NUM_W          28
`define SPM_DEN_W          16
`define SPM_DIV_STEPS      5'h1C
`define SPM_FREQ_W         16
`define SPM_SLEEP_W        32
`define SPM_WIN_LAST       12'hFFF
`define SPM_GATE_TIME_MS   1000
`define SPM_GATE_CYCLES    ((`SPM_CLK_HZ / 1000) * `SPM_GATE_TIME_MS)
`define SPM_SRC_ANALOG     2'h0
`define SPM_SRC_PULSE      2'h1
`define SPM_SRC_SERIAL     2'h2
`define SPM_SRC_FREQ       2'h3
`define SPM_SHP_DIRECT     2'h0
`define SPM_SHP_LINEAR     2'h1
`define SPM_SHP_STAIR      2'h2
`define SPM_SHP_FWDREV     2'h3

`endif

// >>> spm_pkg.sv
// types for the speed command and profile mapper
// assumes spm_defines.svh is on the include path
package spm_pkg;
  `include "spm_defines.svh"

  typedef logic [`SPM_DUTY_W-1:0] spm_duty_t;
  typedef logic [`SPM_VMAG_W-1:0] spm_vmag_t;

  typedef enum logic [1:0] {
    ST_CMD      = 2'b00,
    ST_CMD_DIV  = 2'b01,
    ST_PROF     = 2'b10,
    ST_PROF_DIV = 2'b11
  } spm_state_e;

  typedef struct packed {
    logic                     busy;
    logic [4:0]               cnt;
    logic [`SPM_DEN_W:0]      rem;
    logic [`SPM_NUM_W-1:0]    quo;
    logic                     done;
  } spm_div_s;
endpackage : spm_pkg

// >>> spm_div_if.sv
// carrier between the mapper and its divider
// assumes one clock shared by both ends
`timescale 1ns/1ps
`include "spm_defines.svh"
interface spm_div_if;
  import spm_pkg::*;
  logic                  start;
  logic [`SPM_NUM_W-1:0] num;
  logic [`SPM_DEN_W-1:0] den;
  logic                  done;
  logic [`SPM_NUM_W-1:0] quot;
  modport client (output start, output num, output den,
                  input done, input quot);
  modport server (input start, input num, input den,
                  output done, output quot);
endinterface : spm_div_if

// >>> spm_divider.sv
// sequential restoring divider, one quotient bit per clock
// assumes den is nonzero and num, den are held while busy
`timescale 1ns/1ps
`include "spm_defines.svh"
module spm_divider
  import spm_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  spm_div_if.server bus
);
  spm_div_s s_q;
  spm_div_s s_d;
  logic [`SPM_DEN_W:0] trial;

  always_comb
  begin
    s_d = s_q;
    trial = '0;
    s_d.done = 1'b0;
    if (!s_q.busy && bus.start)
    begin
      s_d.busy = 1'b1;
      s_d.cnt = `SPM_DIV_STEPS;
      s_d.rem = '0;
      s_d.quo = bus.num;
    end
    else if (s_q.busy)
    begin
      trial = {s_q.rem[`SPM_DEN_W-1:0], s_q.quo[`SPM_NUM_W-1]};
      s_d.quo = {s_q.quo[`SPM_NUM_W-2:0], 1'b0};
      if (trial >= {1'b0, bus.den})
      begin
        trial = trial - {1'b0, bus.den};
        s_d.quo[0] = 1'b1;
      end
      s_d.rem = trial;
      s_d.cnt = s_q.cnt - 5'h01;
      if (s_q.cnt == 5'h01)
      begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign bus.done = s_q.done;
  assign bus.quot = s_q.quo;
endmodule : spm_divider

// >>> spm_mapper.sv
// speed command source selection, serial sleep/standby, profile shaping
// assumes all inputs synchronous to clk and stable settings
`timescale 1ns/1ps
`include "spm_defines.svh"

// Summary of operation
// [R1] source 10: duty command is the serial speed command value
// [R2] serial: sleep when pin low after zero command longer than entry delay
// [R3] serial: leave sleep when pin above exit level, resume serial command
// [R4] serial: standby while command at or below threshold and pin above exit
// [R5] source 11: duty command linear in measured pin frequency
// [R6] frequency at or below standby entry gives zero duty
// [R7] linear from standby exit to ceiling, full scale above ceiling
// [R8] shape 00: velocity target follows duty command directly
// [R9] direct shape: changes smaller than deadband leave target unchanged while command is above deadband
// [R10] zero command stops the motor for every shape
// [R11] shape 01: piecewise linear through breakpoints A to E
// [R12] while off, start only above low turn-on point, to low plateau
// [R13] hold low plateau above low turn-off, else low cutoff velocity
// [R14] hold high plateau up to high turn-off, else high cutoff velocity
// [R15] while off, start high side only below high turn-on point
// [R16] shape 10: velocity steps at each breakpoint
// [R17] shape 11: direction reverses at breakpoint C
// [R18] forward: interpolate to A, hold A to B, off above B
// [R19] reverse above D: hold D to E, interpolate to high plateau
// [R20] host sets sleep delay longer than pulse low time at lowest duty
// [R21] source 01: duty command from pulse duty cycle on speed pin
// [R22] zero top velocity limit clamps target to zero
// [R23] profile re-evaluated continuously on any command or setting change
// [R24] zero stop first, then breakpoints searched in ascending order
module spm_mapper
  import spm_pkg::*;
#(
  parameter int GATE_CYCLES = `SPM_GATE_CYCLES
)
(
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic [1:0]               speed_source,
  input  wire logic [1:0]               profile_shape,
  input  wire logic                     speed_pin,
  input  wire logic                     pin_below_sleep,
  input  wire logic                     pin_above_wake,
  input  wire spm_duty_t                analog_duty,
  input  wire spm_duty_t                serial_speed_cmd,
  input  wire spm_duty_t                serial_standby_thr,
  input  wire logic [`SPM_SLEEP_W-1:0]  sleep_entry_cycles,
  input  wire logic [`SPM_FREQ_W-1:0]   freq_standby_entry,
  input  wire logic [`SPM_FREQ_W-1:0]   freq_standby_exit,
  input  wire logic [`SPM_FREQ_W-1:0]   freq_ceiling,
  input  wire spm_duty_t                command_deadband,
  input  wire spm_vmag_t                max_velocity,
  input  wire spm_duty_t                low_turn_on_point,
  input  wire spm_duty_t                low_turn_off_point,
  input  wire spm_duty_t                low_plateau_end,
  input  wire spm_duty_t                duty_a,
  input  wire spm_duty_t                duty_b,
  input  wire spm_duty_t                duty_c,
  input  wire spm_duty_t                duty_d,
  input  wire spm_duty_t                duty_e,
  input  wire spm_duty_t                high_plateau_start,
  input  wire spm_duty_t                high_turn_on_point,
  input  wire spm_duty_t                high_turn_off_point,
  input  wire spm_vmag_t                low_plateau_velocity,
  input  wire spm_vmag_t                low_cutoff_velocity,
  input  wire spm_vmag_t                velocity_a,
  input  wire spm_vmag_t                velocity_b,
  input  wire spm_vmag_t                velocity_d,
  input  wire spm_vmag_t                velocity_e,
  input  wire spm_vmag_t                high_plateau_velocity,
  input  wire spm_vmag_t                high_cutoff_velocity,
  input  wire spm_vmag_t                velocity_c,
  output logic [`SPM_FREQ_W-1:0]        measured_freq,
  output spm_duty_t                     duty_command,
  output logic signed [`SPM_VEL_W-1:0]  velocity_target,
  output logic                          sleep_state,
  output logic                          standby_state
);
  typedef struct packed {
    spm_state_e               st;
    logic                     pin_prev;
    logic [31:0]              gate_cnt;
    logic [`SPM_FREQ_W-1:0]   edge_cnt;
    logic [`SPM_FREQ_W-1:0]   freq;
    logic [`SPM_DUTY_W-1:0]   win_cnt;
    logic [`SPM_DUTY_W:0]     high_cnt;
    spm_duty_t                pwm_duty;
    logic [`SPM_SLEEP_W-1:0]  zero_cnt;
    logic                     sleep;
    logic                     standby;
    spm_duty_t                duty;
    spm_duty_t                dref;
    logic signed [`SPM_VEL_W-1:0] vel;
    spm_vmag_t                y0;
    logic                     dy_neg;
    logic                     neg;
    logic                     div_start;
    logic [`SPM_NUM_W-1:0]    div_num;
    logic [`SPM_DEN_W-1:0]    div_den;
  } spm_main_s;

  spm_main_s s_q;
  spm_main_s s_d;
  spm_div_if div_bus ();

  spm_divider u_div (
    .clk  (clk),
    .srst (srst),
    .bus  (div_bus)
  );

  assign div_bus.start = s_q.div_start;
  assign div_bus.num   = s_q.div_num;
  assign div_bus.den   = s_q.div_den;

  function automatic spm_vmag_t vmin(input spm_vmag_t a, input spm_vmag_t b);
    vmin = (a < b) ? a : b;
  endfunction : vmin

  function automatic logic signed [`SPM_VEL_W-1:0] vsign(
    input spm_vmag_t m, input logic n);
    vsign = n ? -$signed({1'b0, m}) : $signed({1'b0, m});
  endfunction : vsign

  spm_duty_t               px [7];
  spm_vmag_t               py [7];
  spm_duty_t               d;
  spm_duty_t               x0;
  spm_duty_t               x1;
  spm_vmag_t               y1;
  spm_vmag_t               mag;
  spm_vmag_t               dy;
  logic                    interp;
  logic                    found;
  logic                    off_now;
  logic [`SPM_DUTY_W+`SPM_VMAG_W-1:0] prod;
  logic [`SPM_FREQ_W-1:0]  fspan;
  spm_vmag_t               qmag;

  always_comb
  begin
    s_d = s_q;
    s_d.div_start = 1'b0;
    d = s_q.duty;
    x0 = '0;
    x1 = '0;
    y1 = '0;
    mag = '0;
    dy = '0;
    interp = 1'b0;
    found = 1'b0;
    off_now = (s_q.vel == '0);
    prod = '0;
    fspan = '0;
    qmag = '0;
    px = '{low_plateau_end, duty_a, duty_b, duty_c, duty_d, duty_e,
           high_plateau_start};
    py = '{low_plateau_velocity, velocity_a, velocity_b, velocity_c,
           velocity_d, velocity_e, high_plateau_velocity};

    // frequency gate: rising edges counted per gate window
    s_d.pin_prev = speed_pin;
    if (speed_pin && !s_q.pin_prev && s_q.edge_cnt != '1)
      s_d.edge_cnt = s_q.edge_cnt + 16'h0001;
    if (s_q.gate_cnt == 32'(GATE_CYCLES - 1))
    begin
      s_d.gate_cnt = '0;
      s_d.freq = s_d.edge_cnt;
      s_d.edge_cnt = '0;
    end
    else
      s_d.gate_cnt = s_q.gate_cnt + 32'h0000_0001;

    // pulse duty: high cycles over a 4096-cycle window
    s_d.win_cnt = s_q.win_cnt + 12'h001;
    s_d.high_cnt = s_q.high_cnt + {12'h000, speed_pin};
    if (s_q.win_cnt == `SPM_WIN_LAST)
    begin
      s_d.pwm_duty = s_d.high_cnt[`SPM_DUTY_W] ? `SPM_DUTY_FS
                                               : s_d.high_cnt[11:0]; // R21
      s_d.high_cnt = '0;
    end

    // serial sleep and standby
    if (speed_source == `SPM_SRC_SERIAL)
    begin
      if (serial_speed_cmd != '0)
        s_d.zero_cnt = '0;
      else if (s_q.zero_cnt != '1)
        s_d.zero_cnt = s_q.zero_cnt + 32'h0000_0001;
      if (s_q.sleep && pin_above_wake)
        s_d.sleep = 1'b0; // R3
      else if (pin_below_sleep && serial_speed_cmd == '0 &&
               s_q.zero_cnt >= sleep_entry_cycles)
        s_d.sleep = 1'b1; // R2
      s_d.standby = (serial_speed_cmd <= serial_standby_thr) &&
                    pin_above_wake; // R4
    end
    else
    begin
      s_d.zero_cnt = '0;
      s_d.sleep = 1'b0;
      s_d.standby = 1'b0;
    end

    case (s_q.st)
      ST_CMD:
      begin
        s_d.st = ST_PROF;
        case (speed_source)
          `SPM_SRC_PULSE:  s_d.duty = s_q.pwm_duty; // R21
          `SPM_SRC_SERIAL: s_d.duty = (s_q.sleep || s_d.standby) ? '0
                                      : serial_speed_cmd; // R1 R4
          `SPM_SRC_FREQ:
          begin
            if (s_q.freq <= freq_standby_entry ||
                s_q.freq < freq_standby_exit)
              s_d.duty = '0; // R6
            else if (s_q.freq >= freq_ceiling)
              s_d.duty = `SPM_DUTY_FS; // R7
            else
            begin
              fspan = s_q.freq - freq_standby_exit;
              s_d.div_num = `SPM_NUM_W'(fspan * `SPM_DUTY_FS); // R5
              s_d.div_den = freq_ceiling - freq_standby_exit;
              s_d.div_start = 1'b1;
              s_d.st = ST_CMD_DIV;
            end
          end
          default:         s_d.duty = analog_duty;
        endcase
      end
      ST_CMD_DIV:
      begin
        if (div_bus.done)
        begin
          s_d.duty = (div_bus.quot > `SPM_NUM_W'(`SPM_DUTY_FS)) ?
                     `SPM_DUTY_FS : div_bus.quot[`SPM_DUTY_W-1:0]; // R7
          s_d.st = ST_PROF;
        end
      end
      ST_PROF:
      begin
        s_d.st = ST_CMD; // R23
        s_d.neg = 1'b0;
        if (d == '0 || max_velocity == '0)
          mag = '0; // R10 R22 R24
        else if (profile_shape == `SPM_SHP_DIRECT)
        begin
          prod = d * max_velocity; // R8
          if (d <= command_deadband ||
              (d > s_q.dref ? d - s_q.dref : s_q.dref - d)
                >= command_deadband)
          begin
            mag = prod[`SPM_DUTY_W+`SPM_VMAG_W-1:`SPM_DUTY_W];
            s_d.dref = d;
          end
          else
            mag = s_q.vel[`SPM_VMAG_W-1:0]; // R9
        end
        else if (profile_shape == `SPM_SHP_FWDREV)
        begin
          s_d.neg = (d >= duty_c); // R17
          if (d < low_turn_off_point)
            mag = low_cutoff_velocity;
          else if (d <= low_plateau_end)
            mag = (off_now && d <= low_turn_on_point) ? '0
                  : low_plateau_velocity; // R12 R13
          else if (d < duty_a)
          begin
            x0 = low_plateau_end;
            x1 = duty_a;
            s_d.y0 = low_plateau_velocity;
            y1 = velocity_a;
            interp = 1'b1; // R18
          end
          else if (d <= duty_b)
            mag = velocity_a; // R18
          else if (d < duty_d)
            mag = '0; // R18
          else if (d <= duty_e)
            mag = velocity_d; // R19
          else if (d < high_plateau_start)
          begin
            x0 = duty_e;
            x1 = high_plateau_start;
            s_d.y0 = velocity_e;
            y1 = high_plateau_velocity;
            interp = 1'b1; // R19
          end
          else if (d <= high_turn_off_point)
            mag = (off_now && d >= high_turn_on_point) ? '0
                  : high_plateau_velocity; // R14 R15
          else
            mag = high_cutoff_velocity; // R14
        end
        else
        begin
          if (d < low_turn_off_point)
            mag = low_cutoff_velocity; // R13
          else if (d <= low_plateau_end)
            mag = (off_now && d <= low_turn_on_point) ? '0
                  : low_plateau_velocity; // R12 R13
          else if (d < high_plateau_start)
          begin
            for (int i = 0; i < 6; i++)
            begin
              if (!found && d >= px[i] && d < px[i+1])
              begin
                found = 1'b1; // R24
                x0 = px[i];
                x1 = px[i+1];
                s_d.y0 = py[i];
                y1 = py[i+1];
                mag = py[i+1]; // R16
              end
            end
            interp = found && (profile_shape == `SPM_SHP_LINEAR); // R11
          end
          else if (d <= high_turn_off_point)
            mag = (off_now && d >= high_turn_on_point) ? '0
                  : high_plateau_velocity; // R14 R15
          else
            mag = high_cutoff_velocity; // R14
        end
        if (interp)
        begin
          s_d.dy_neg = (y1 < s_d.y0);
          dy = s_d.dy_neg ? s_d.y0 - y1 : y1 - s_d.y0;
          prod = (d - x0) * dy;
          s_d.div_num = `SPM_NUM_W'(prod);
          s_d.div_den = `SPM_DEN_W'(x1 - x0);
          s_d.div_start = 1'b1;
          s_d.st = ST_PROF_DIV;
        end
        else
          s_d.vel = vsign(vmin(mag, max_velocity), s_d.neg); // R22
      end
      ST_PROF_DIV:
      begin
        if (div_bus.done)
        begin
          qmag = div_bus.quot[`SPM_VMAG_W-1:0];
          mag = s_q.dy_neg ? s_q.y0 - qmag : s_q.y0 + qmag; // R11
          s_d.vel = vsign(vmin(mag, max_velocity), s_q.neg);
          s_d.st = ST_CMD;
        end
      end
      default: s_d.st = ST_CMD;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign measured_freq   = s_q.freq;
  assign duty_command    = s_q.duty;
  assign velocity_target = s_q.vel;
  assign sleep_state     = s_q.sleep;
  assign standby_state   = s_q.standby;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_serial_duty_take: assert property ( // R1
    s_q.st == ST_CMD && speed_source == `SPM_SRC_SERIAL && !s_q.sleep
    && serial_speed_cmd > serial_standby_thr
    |=> duty_command == $past(serial_speed_cmd))
    else $error("serial command not taken as duty");
  a_sleep_entry: assert property ( // R2
    speed_source == `SPM_SRC_SERIAL && !sleep_state && pin_below_sleep
    && serial_speed_cmd == '0 && s_q.zero_cnt >= sleep_entry_cycles
    ##1 speed_source == `SPM_SRC_SERIAL |-> sleep_state)
    else $error("sleep not entered after zero command delay");
  a_sleep_exit: assert property ( // R3
    sleep_state && pin_above_wake && speed_source == `SPM_SRC_SERIAL
    |=> !sleep_state)
    else $error("sleep not left on wake level");
  a_standby_hold: assert property ( // R4
    speed_source == `SPM_SRC_SERIAL && pin_above_wake
    && serial_speed_cmd <= serial_standby_thr |=> standby_state)
    else $error("standby not held");
  a_freq_standby: assert property ( // R6
    s_q.st == ST_CMD && speed_source == `SPM_SRC_FREQ
    && measured_freq <= freq_standby_entry |=> duty_command == '0)
    else $error("low frequency did not zero duty");
  a_freq_clamp: assert property ( // R7
    s_q.st == ST_CMD && speed_source == `SPM_SRC_FREQ
    && measured_freq > freq_standby_exit && measured_freq > freq_ceiling
    |=> duty_command == `SPM_DUTY_FS)
    else $error("high frequency not clamped to full scale");
  a_zero_stop: assert property ( // R10
    s_q.st == ST_PROF && duty_command == '0 ##1 1'b1
    |-> velocity_target == '0 && s_q.st == ST_CMD)
    else $error("zero command did not stop motor");
  a_max_zero: assert property ( // R22
    s_q.st == ST_PROF && max_velocity == '0 |=> velocity_target == '0)
    else $error("zero top velocity not clamped");
  a_div_bound: assert property ( // R23
    s_q.st == ST_PROF_DIV |-> ##[1:32] s_q.st == ST_CMD)
    else $error("profile evaluation stuck in divide");

  c_sleep_cycle: cover property (sleep_state ##[1:1000] !sleep_state);
  c_reverse_run: cover property (velocity_target < 0);
  c_interp_done: cover property (s_q.st == ST_PROF_DIV ##1 div_bus.done);
endmodule : spm_mapper

// >>> spm_host_model.sv
// host side model driving the speed pin as pulse or square wave
// assumes period and high_len are held steady while running
`timescale 1ns/1ps
module spm_host_model
(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [15:0] period,
  input  wire logic [15:0] high_len,
  output logic             speed_pin
);
  logic [15:0] cnt_q;

  // zero period parks the pin low
  always_ff @(posedge clk)
  begin
    if (srst || period == 16'h0000)
    begin
      cnt_q     <= 16'h0000;
      speed_pin <= 1'b0;
    end
    else
    begin
      cnt_q     <= (cnt_q >= period - 16'h0001) ? 16'h0000 : cnt_q + 16'h0001;
      speed_pin <= (cnt_q < high_len);
    end
  end
endmodule : spm_host_model

// >>> tb.sv
// self-checking bench for the speed command and profile mapper
// assumes a 100 cycle frequency gate and the host model on the pin
`timescale 1ns/1ps
module tb;
  import spm_pkg::*;
  logic                  clk = 1'b0;
  logic                  srst = 1'b1;
  logic [1:0]            src = 2'h2;
  logic [1:0]            shp = 2'h0;
  logic                  below = 1'b0;
  logic                  above = 1'b0;
  spm_duty_t             ana = 12'h000;
  spm_duty_t             scmd = 12'h000;
  spm_duty_t             thr = 12'h010;
  logic [31:0]           sleep_dly = 32'h0000_0014;
  spm_duty_t             db = 12'h040;
  spm_vmag_t             mx = 15'h7FFF;
  logic [15:0]           per = 16'h0000;
  logic [15:0]           hi = 16'h0000;
  spm_duty_t             bp [11];
  spm_vmag_t             vl [9];
  spm_duty_t             lc [7];
  logic [15:0]           lv [7];
  logic                  pin;
  logic [15:0]           mf;
  spm_duty_t             duty;
  logic signed [15:0]    vel;
  logic                  slp;
  logic                  stby;
  int                    fail_count = 0;
  int                    comparisons = 0;
  int                    cyc = 0;
  int                    i;

  always #20 clk = ~clk;

  spm_host_model spm_host_model_i (.clk(clk), .srst(srst), .period(per),
    .high_len(hi), .speed_pin(pin));

  spm_mapper #(.GATE_CYCLES(100)) spm_mapper_i (
    .clk(clk), .srst(srst), .speed_source(src), .profile_shape(shp),
    .speed_pin(pin), .pin_below_sleep(below), .pin_above_wake(above),
    .analog_duty(ana), .serial_speed_cmd(scmd), .serial_standby_thr(thr),
    .sleep_entry_cycles(sleep_dly), .freq_standby_entry(16'h0002),
    .freq_standby_exit(16'h0004), .freq_ceiling(16'h0008),
    .command_deadband(db), .max_velocity(mx),
    .low_turn_on_point(bp[0]), .low_turn_off_point(bp[1]),
    .low_plateau_end(bp[2]), .duty_a(bp[3]), .duty_b(bp[4]),
    .duty_c(bp[5]), .duty_d(bp[6]), .duty_e(bp[7]),
    .high_plateau_start(bp[8]), .high_turn_on_point(bp[9]),
    .high_turn_off_point(bp[10]), .low_plateau_velocity(vl[0]),
    .low_cutoff_velocity(vl[1]), .velocity_a(vl[2]), .velocity_b(vl[3]),
    .velocity_c(vl[4]), .velocity_d(vl[5]), .velocity_e(vl[6]),
    .high_plateau_velocity(vl[7]), .high_cutoff_velocity(vl[8]),
    .measured_freq(mf), .duty_command(duty), .velocity_target(vel),
    .sleep_state(slp), .standby_state(stby));

  task automatic miss(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : miss

  task automatic chk_duty(input spm_duty_t got, input spm_duty_t exp);
    miss({4'h0, got}, {4'h0, exp});
  endtask : chk_duty

  task automatic chk_vel(input logic [15:0] got, input logic [15:0] exp);
    miss(got, exp);
  endtask : chk_vel

  task automatic chk_flag(input logic got, input logic exp);
    miss({15'h0000, got}, {15'h0000, exp});
  endtask : chk_flag

  task automatic chk_freq(input logic [15:0] got, input logic [15:0] exp);
    miss(got, exp);
  endtask : chk_freq

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic set_cmd(input spm_duty_t v);
    @(posedge clk);
    scmd <= v;
    settle(70);
  endtask : set_cmd

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fail_count++;
      wrap_up();
    end
  end

  initial
  begin
    bp = '{12'h100, 12'h080, 12'h200, 12'h400, 12'h600, 12'h800,
           12'hA00, 12'hC00, 12'hD00, 12'hE80, 12'hF00};
    vl = '{15'h0100, 15'h0050, 15'h0200, 15'h0300, 15'h0400, 15'h0500,
           15'h0600, 15'h0700, 15'h0080};
    lc = '{12'h0C0, 12'h180, 12'h0A0, 12'h060, 12'h500, 12'hE00, 12'hF80};
    lv = '{16'h0000, 16'h0100, 16'h0100, 16'h0050, 16'h0280, 16'h0700,
           16'h0080};
    settle(8);
    srst <= 1'b0;
    settle(1);
    chk_duty(duty, 12'h000);
    chk_vel(vel, 16'h0000);
    set_cmd(12'h800);
    chk_duty(duty, 12'h800);
    chk_vel(vel, 16'h3FFF);
    set_cmd(12'h820);
    chk_vel(vel, 16'h3FFF);
    set_cmd(12'h900);
    chk_vel(vel, 16'h47FF);
    mx <= 15'h0000;
    settle(70);
    chk_vel(vel, 16'h0000);
    mx <= 15'h7FFF;
    set_cmd(12'h000);
    chk_vel(vel, 16'h0000);
    src <= 2'h0;
    ana <= 12'h400;
    settle(70);
    chk_duty(duty, 12'h400);
    chk_vel(vel, 16'h1FFF);
    src <= 2'h2;
    shp <= 2'h1;
    set_cmd(12'h000);
    chk_vel(vel, 16'h0000);
    for (i = 0; i < 7; i++)
    begin
      set_cmd(lc[i]);
      chk_vel(vel, lv[i]);
    end
    shp <= 2'h2;
    set_cmd(12'h500);
    chk_vel(vel, 16'h0300);
    shp <= 2'h3;
    set_cmd(12'h510);
    chk_vel(vel, 16'h0200);
    set_cmd(12'hB00);
    chk_vel(vel, 16'hFB00);
    set_cmd(12'h900);
    chk_vel(vel, 16'h0000);
    shp <= 2'h0;
    set_cmd(12'h300);
    scmd <= 12'h000;
    below <= 1'b1;
    settle(10);
    chk_flag(slp, 1'b0);
    settle(30);
    chk_flag(slp, 1'b1);
    above <= 1'b1;
    below <= 1'b0;
    settle(3);
    chk_flag(slp, 1'b0);
    set_cmd(12'h008);
    chk_flag(stby, 1'b1);
    chk_duty(duty, 12'h000);
    set_cmd(12'h020);
    chk_flag(stby, 1'b0);
    chk_duty(duty, 12'h020);
    above <= 1'b0;
    src <= 2'h3;
    per <= 16'h000A;
    hi <= 16'h0005;
    settle(400);
    chk_freq(mf, 16'h000A);
    chk_duty(duty, 12'hFFF);
    per <= 16'h0014;
    hi <= 16'h000A;
    settle(400);
    chk_freq(mf, 16'h0005);
    chk_duty(duty, 12'h3FF);
    per <= 16'h0064;
    hi <= 16'h0032;
    settle(400);
    chk_freq(mf, 16'h0001);
    chk_duty(duty, 12'h000);
    src <= 2'h1;
    per <= 16'h0010;
    hi <= 16'h0008;
    sleep_dly <= 32'h0000_0010;
    settle(8400);
    chk_duty(duty, 12'h800);
    wrap_up();
  end
endmodule : tb
